// [hdl/sdci_cfg.svh]
// Constants for the SDRAM command interface model.
`ifndef SDCI_CFG_SVH
`define SDCI_CFG_SVH
`define SDCI_CLK_NS      50
`define SDCI_REF_WIN_MS  64
`define SDCI_REF_ROWS    4096
`define SDCI_REF_NS      ((`SDCI_REF_WIN_MS * 1000000) / `SDCI_REF_ROWS)
`define SDCI_REF_CYC     (`SDCI_REF_NS / `SDCI_CLK_NS)
`define SDCI_OFS_STATUS  12'h000
`define SDCI_OFS_MODE    12'h004
`define SDCI_OFS_REFCNT  12'h008
`define SDCI_OFS_CTRL    12'h00c
`define SDCI_CTRL_RST    32'h0000_0002
`define SDCI_CTRL_CLR    0
`define SDCI_CTRL_DEC    1
`define SDCI_MODE_RST    12'h020
`define SDCI_BL_LSB      0
`define SDCI_BL_MSB      2
`define SDCI_BT_BIT      3
`define SDCI_CL_LSB      4
`define SDCI_CL_MSB      6
`define SDCI_WB_BIT      9
`define SDCI_AP_BIT      10
`define SDCI_BL_FULL     3'h7
`define SDCI_CL3         3'h3
`endif

// [hdl/sdci_pkg.sv]
// Types shared by the SDRAM command interface model.
package sdci_pkg;
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bank_pick_lines;
        logic [11:0] addr;
        logic [1:0]  dqm;
    } sdci_pins_t;

    typedef enum logic [3:0] {
        SDCI_RUN  = 4'h1,
        SDCI_DOWN = 4'h2,
        SDCI_SUSP = 4'h4,
        SDCI_SELF = 4'h8
    } sdci_pwr_t;

    typedef enum logic [2:0] {
        SDCI_MRS = 3'h0,
        SDCI_REF = 3'h1,
        SDCI_PRE = 3'h2,
        SDCI_ACT = 3'h3,
        SDCI_WR  = 3'h4,
        SDCI_RD  = 3'h5,
        SDCI_BST = 3'h6,
        SDCI_NOP = 3'h7
    } sdci_cmd_t;
endpackage

// [hdl/sdci_top.sv]
// SDRAM device model: command decode, banks, bursts, masks, power states, APB status.
`timescale 1ns/1ps
`include "sdci_cfg.svh"
// ------------------------------------------------------------
// What this block does
// - Bursts of 1, 2, 4, 8 or page
// - Burst columns come from internal counter
// - New column read accepted every cycle
// - Mode sets length, latency, burst order
// - Read latency is two or three
// - Auto refresh and self refresh supported
// - Twelve row lines, nine column lines
// - Bank pick lines choose the bank
// - Four banks of 2M 16-bit words
// - Data lines turn with the operation
// - Deselected decoder ignores commands, work continues
// - Strobe levels at edge pick command
// - All inputs taken on rising edge
// - Read mask floats outputs two later
// - Write mask blocks same-cycle data
// - Masks act per byte
// - Clock enable low stops command, burst and data clocking
// - Burst reads with single-word writes mode
// - Auto precharge or explicit precharge
// - Banks work independently
// ------------------------------------------------------------
module sdci_top #(
    parameter int ROW_W = 12,
    parameter int COL_W = 9
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                cke,
    input  wire sdci_pkg::sdci_pins_t pins,
    input  wire logic [15:0]         dq_in,
    output logic      [15:0]         dq_out,
    output logic      [1:0]          dq_oe_n
);
    localparam int AW = 2 + ROW_W + COL_W;
    localparam logic [8:0] REF_LAST = 9'(`SDCI_REF_CYC - 1);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    sdci_pkg::sdci_cmd_t cmd;
    sdci_pkg::sdci_pwr_t pwr_q;
    logic                adv;
    logic                rw_go;
    logic [31:0]         ctrl_q;
    logic [11:0]         mode_q;
    logic                cl3;

    // A deselected or software-disabled decoder sees a no-op only.
    assign cmd = (!pins.cs_n && ctrl_q[`SDCI_CTRL_DEC]) ?
        sdci_pkg::sdci_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n})
        : sdci_pkg::SDCI_NOP;
    // Clock enable low freezes the command, mode, burst, bank and read-pipe state for that edge.
    assign adv   = cke;
    assign rw_go = adv && (cmd == sdci_pkg::SDCI_RD || cmd == sdci_pkg::SDCI_WR);
    assign cl3   = mode_q[`SDCI_CL_MSB:`SDCI_CL_LSB] == `SDCI_CL3;

    // Burst length from the mode code; illegal codes fall back to one word.
    function automatic logic [COL_W:0] burst_len(input logic [2:0] code);
        case (code)
            3'h0:          burst_len = (COL_W + 1)'(1);
            3'h1:          burst_len = (COL_W + 1)'(2);
            3'h2:          burst_len = (COL_W + 1)'(4);
            3'h3:          burst_len = (COL_W + 1)'(8);
            `SDCI_BL_FULL: burst_len = (COL_W + 1)'(1) << COL_W;
            default:       burst_len = (COL_W + 1)'(1);
        endcase
    endfunction

    // Column of burst step cnt; wraps inside the burst-sized block.
    function automatic logic [COL_W-1:0] burst_col(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] cnt,
        input logic [COL_W:0]   len,
        input logic             inter
    );
        logic [COL_W-1:0] msk;
        msk = COL_W'(len - (COL_W + 1)'(1));
        burst_col = (start & ~msk) | ((inter ? (start ^ cnt) : (start + cnt)) & msk);
    endfunction

    // ------------------------------------------------------------
    // Mode setting
    // ------------------------------------------------------------
    // Mode load takes the address lines as the new setting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `SDCI_MODE_RST;
        end else if (adv && cmd == sdci_pkg::SDCI_MRS) begin
            mode_q <= pins.addr;
        end
    end

    // ------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------
    logic             bst_act_q, bst_wr_q, bst_ap_q, bst_ilv_q;
    logic [1:0]       bst_bank_q;
    logic [COL_W-1:0] bst_start_q, bst_cnt_q;
    logic [COL_W:0]   bst_len_q, new_len, acc_len;
    logic             acc_v, acc_wr, acc_last, acc_ap;
    logic [1:0]       acc_bank;
    logic [COL_W-1:0] acc_col, acc_cnt;
    logic [AW-1:0]    acc_addr;
    logic [3:0]       open_q;
    logic [ROW_W-1:0] row_q [4];

    // Writes shrink to one word when single-write mode is set.
    assign new_len = (cmd == sdci_pkg::SDCI_WR && mode_q[`SDCI_WB_BIT]) ?
        (COL_W + 1)'(1) : burst_len(mode_q[`SDCI_BL_MSB:`SDCI_BL_LSB]);

    // A fresh command wins over a running burst, so columns may change each cycle.
    always_comb begin
        acc_v    = adv && (rw_go || bst_act_q);
        acc_wr   = rw_go ? (cmd == sdci_pkg::SDCI_WR) : bst_wr_q;
        acc_bank = rw_go ? pins.bank_pick_lines : bst_bank_q;
        acc_cnt  = rw_go ? '0 : bst_cnt_q;
        acc_len  = rw_go ? new_len : bst_len_q;
        acc_ap   = rw_go ? pins.addr[`SDCI_AP_BIT] : bst_ap_q;
        acc_col  = rw_go ? pins.addr[COL_W-1:0] :
            burst_col(bst_start_q, bst_cnt_q, bst_len_q, bst_ilv_q);
        acc_last = ((COL_W + 1)'(acc_cnt) + (COL_W + 1)'(1)) == acc_len;
        acc_addr = {acc_bank, row_q[acc_bank], acc_col};
    end

    // Burst counter steps once per enabled edge until the last word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bst_act_q   <= 1'b0;
            bst_wr_q    <= 1'b0;
            bst_ap_q    <= 1'b0;
            bst_ilv_q   <= 1'b0;
            bst_bank_q  <= 2'h0;
            bst_start_q <= '0;
            bst_cnt_q   <= '0;
            bst_len_q   <= '0;
        end else if (adv) begin
            if (rw_go) begin
                bst_act_q   <= !acc_last;
                bst_wr_q    <= acc_wr;
                bst_ap_q    <= acc_ap;
                bst_ilv_q   <= mode_q[`SDCI_BT_BIT];
                bst_bank_q  <= acc_bank;
                bst_start_q <= acc_col;
                bst_cnt_q   <= COL_W'(1);
                bst_len_q   <= new_len;
            end else if (cmd == sdci_pkg::SDCI_BST || (cmd == sdci_pkg::SDCI_PRE &&
                         (pins.addr[`SDCI_AP_BIT] || pins.bank_pick_lines == bst_bank_q))) begin
                bst_act_q <= 1'b0;
            end else if (bst_act_q) begin
                bst_cnt_q <= bst_cnt_q + COL_W'(1);
                if (acc_last) begin
                    bst_act_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Bank rows
    // ------------------------------------------------------------
    // Each bank keeps its own open flag and row, so banks overlap freely.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_q <= 4'h0;
            for (int b = 0; b < 4; b++) begin
                row_q[b] <= '0;
            end
        end else if (adv) begin
            if (cmd == sdci_pkg::SDCI_ACT) begin
                open_q[pins.bank_pick_lines] <= 1'b1;
                row_q[pins.bank_pick_lines]  <= pins.addr[ROW_W-1:0];
            end else if (cmd == sdci_pkg::SDCI_PRE) begin
                if (pins.addr[`SDCI_AP_BIT]) begin
                    open_q <= 4'h0;
                end else begin
                    open_q[pins.bank_pick_lines] <= 1'b0;
                end
            end
            if (acc_v && acc_last && acc_ap) begin
                open_q[acc_bank] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Storage and data path
    // ------------------------------------------------------------
    logic [15:0] mem [2**AW];
    logic [15:0] rd_q [3];
    logic [2:0]  rv_q;
    logic [1:0]  mk_q [2];
    logic [1:0]  lane_we;
    logic        out_v;

    assign out_v  = cl3 ? rv_q[2] : rv_q[1];
    assign dq_out = cl3 ? rd_q[2] : rd_q[1];

    // Byte lanes: write masks act at once, read masks two edges later.
    for (genvar i = 0; i < 2; i++) begin : g_lane
        assign lane_we[i] = acc_v && acc_wr && !pins.dqm[i];
        assign dq_oe_n[i] = !(out_v && !mk_q[1][i]);
    end

    // One process writes the array; a process per lane would give it two drivers.
    always_ff @(posedge pclk) begin
        for (int l = 0; l < 2; l++) begin
            if (lane_we[l]) begin
                mem[acc_addr][8*l +: 8] <= dq_in[8*l +: 8];
            end
        end
    end

    // Read pipe holds still under clock suspend, like the burst, bank and mode state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rv_q <= 3'h0;
            for (int s = 0; s < 3; s++) begin
                rd_q[s] <= 16'h0000;
            end
            mk_q[0] <= 2'h0;
            mk_q[1] <= 2'h0;
        end else if (adv) begin
            rv_q    <= {rv_q[1:0], acc_v && !acc_wr};
            rd_q[0] <= mem[acc_addr];
            rd_q[1] <= rd_q[0];
            rd_q[2] <= rd_q[1];
            mk_q[0] <= pins.dqm;
            mk_q[1] <= mk_q[0];
        end
    end

    // ------------------------------------------------------------
    // Power states and refresh
    // ------------------------------------------------------------
    logic [31:0] refcnt_q;
    logic [8:0]  stim_q;
    logic        clr_ref;

    // Clock enable low suspends a running burst; else refresh enters self refresh and idle means power-down.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= sdci_pkg::SDCI_RUN;
        end else begin
            unique case (pwr_q)
                sdci_pkg::SDCI_RUN: begin
                    if (!cke) begin
                        if (bst_act_q) begin
                            pwr_q <= sdci_pkg::SDCI_SUSP;
                        end else if (cmd == sdci_pkg::SDCI_REF) begin
                            pwr_q <= sdci_pkg::SDCI_SELF;
                        end else begin
                            pwr_q <= sdci_pkg::SDCI_DOWN;
                        end
                    end
                end
                sdci_pkg::SDCI_DOWN, sdci_pkg::SDCI_SUSP, sdci_pkg::SDCI_SELF: begin
                    if (cke) begin
                        pwr_q <= sdci_pkg::SDCI_RUN;
                    end
                end
            endcase
        end
    end

    // Self refresh paces itself at one row per refresh slot.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stim_q   <= 9'h000;
            refcnt_q <= 32'h0000_0000;
        end else begin
            stim_q <= (pwr_q == sdci_pkg::SDCI_SELF && stim_q != REF_LAST) ?
                stim_q + 9'h001 : 9'h000;
            if ((adv && cmd == sdci_pkg::SDCI_REF) ||
                (pwr_q == sdci_pkg::SDCI_SELF && stim_q == REF_LAST)) begin
                refcnt_q <= refcnt_q + 32'h0000_0001;
            end else if (clr_ref) begin
                refcnt_q <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // APB status and control
    // ------------------------------------------------------------
    logic apb_wr;

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = a == `SDCI_OFS_STATUS || a == `SDCI_OFS_MODE ||
                  a == `SDCI_OFS_REFCNT || a == `SDCI_OFS_CTRL;
    endfunction

    // Zero wait states; read data is latched in the setup cycle.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !reg_hit(paddr);
    assign apb_wr  = psel && penable && pwrite && reg_hit(paddr);
    assign clr_ref = apb_wr && paddr == `SDCI_OFS_CTRL && pwdata[`SDCI_CTRL_CLR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `SDCI_CTRL_RST;
        end else if (apb_wr && paddr == `SDCI_OFS_CTRL) begin
            ctrl_q <= pwdata & (32'h1 << `SDCI_CTRL_DEC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SDCI_OFS_STATUS: prdata <= {23'h0, bst_act_q, pwr_q, open_q};
                `SDCI_OFS_MODE:   prdata <= {20'h0, mode_q};
                `SDCI_OFS_REFCNT: prdata <= refcnt_q;
                `SDCI_OFS_CTRL:   prdata <= ctrl_q;
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_rd2;
        adv && cmd == sdci_pkg::SDCI_RD && !cl3 && pins.dqm == 2'b00;
    endsequence
    sequence s_rd3;
        adv && cmd == sdci_pkg::SDCI_RD && cl3 && pins.dqm == 2'b00;
    endsequence
    sequence s_bl4;
        rw_go && cmd == sdci_pkg::SDCI_RD && mode_q[`SDCI_BL_MSB:`SDCI_BL_LSB] == 3'h2;
    endsequence
    sequence s_quiet;
        adv && !rw_go && cmd != sdci_pkg::SDCI_PRE && cmd != sdci_pkg::SDCI_BST;
    endsequence

    a_read_lat_two: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd2 ##1 adv |=> dq_oe_n == 2'b00) else $error("Read data late at latency two.");
    a_read_lat_three: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd3 ##1 adv ##1 adv |=> dq_oe_n == 2'b00) else $error("Read data late at three.");
    a_mask_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        adv && pins.dqm[1] ##1 adv |=> dq_oe_n[1]) else $error("Masked byte still driven.");
    a_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
        adv && cmd == sdci_pkg::SDCI_WR && pins.dqm == 2'b01 |-> lane_we == 2'b10)
        else $error("Write mask not applied in same cycle.");
    a_burst_four: assert property (@(posedge pclk) disable iff (!presetn)
        s_bl4 ##1 s_quiet [*3] |=> !bst_act_q) else $error("Burst of four not ended.");
    a_burst_runs: assert property (@(posedge pclk) disable iff (!presetn)
        s_bl4 |=> bst_act_q && bst_cnt_q == COL_W'(1)) else $error("Burst did not start.");
    a_act_opens: assert property (@(posedge pclk) disable iff (!presetn)
        adv && cmd == sdci_pkg::SDCI_ACT |=> open_q[$past(pins.bank_pick_lines)])
        else $error("Activated bank not open.");
    a_deselect_idle: assert property (@(posedge pclk) disable iff (!presetn)
        adv && pins.cs_n && !bst_act_q |=> $stable(open_q) && $stable(mode_q))
        else $error("Deselected command took effect.");
    a_suspend_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !cke |=> $stable(bst_cnt_q) && $stable(rv_q)) else $error("State moved with clock off.");
    a_self_stay: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_q == sdci_pkg::SDCI_SELF && !cke |=> pwr_q == sdci_pkg::SDCI_SELF)
        else $error("Self refresh left early.");

endmodule // sdci_top

// [verif/sdci_ctl_model.sv]
// Controller model that drives the SDRAM command pins of the device model.
`timescale 1ns/1ps
module sdci_ctl_model (
    input  wire logic            pclk,
    output sdci_pkg::sdci_pins_t pins,
    output logic                 cke,
    output logic [15:0]          dq_in
);
    // Start deselected with the clock enabled and the data line parked.
    initial begin
        pins  = 20'hfffff;
        cke   = 1'b1;
        dq_in = 16'h5a5a;
    end
    // One command or data word per cycle, changed just after an edge.
    // The bench opens rows first except before the suspend read, and spaces commands by whole 50 ns cycles.
    task automatic issue(input logic c, input logic [2:0] k, input logic [1:0] b,
                         input logic [11:0] a, input logic [1:0] m, input logic [15:0] d);
        pins  <= {c, k, b, a, m};
        dq_in <= d;
        @(posedge pclk);
    endtask
    // Filler cycle; the data line flips so a stale word never looks valid.
    task automatic fill(input logic c, input logic [1:0] m);
        pins  <= {c, 3'h5, 2'h0, 12'h004, m};
        dq_in <= ~dq_in;
        @(posedge pclk);
    endtask
    task automatic pwr(input logic v);
        cke <= v;
    endtask
endmodule // sdci_ctl_model

// [verif/sdci_top_tb.sv]
// Self-checking bench for the SDRAM device model.
`timescale 1ns/1ps
`include "sdci_cfg.svh"
module sdci_top_tb;
    typedef struct packed {
        logic [11:0] mode;
        logic [8:0]  col;
        logic [3:0]  len;
    } sdci_row_t;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 cke;
    sdci_pkg::sdci_pins_t pins;
    logic [15:0]          dq_in;
    logic [15:0]          dq_out;
    logic [1:0]           dq_oe_n;
    logic [31:0]          rd_q;
    logic                 err;
    logic [15:0]          got [8];
    logic [1:0]           oe [8];
    int                   miscompares = 0;
    int                   total_checks = 0;
    int                   cycles = 0;
    sdci_row_t            rows [7];

    sdci_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cke(cke), .pins(pins), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n));
    sdci_ctl_model ctl (.pclk(pclk), .pins(pins), .cke(cke), .dq_in(dq_in));

    // 20 MHz clock and a cycle ceiling well above the planned run.
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            $display("mismatch at %0t: run did not finish", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // APB transfer held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q    = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdreg(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask
    // Command followed by two idle cycles, longer than any controller wait.
    task automatic cmd(input logic [2:0] k, input logic [1:0] b, input logic [11:0] a);
        ctl.issue(1'b0, k, b, a, 2'h0, dq_in);
        ctl.fill(1'b1, 2'h0);
        ctl.fill(1'b1, 2'h0);
    endtask
    // Write burst: word i carries d + i.
    task automatic wr(input logic [1:0] b, input logic [11:0] a, input int n,
                      input logic [1:0] m, input logic [15:0] d);
        ctl.issue(1'b0, sdci_pkg::SDCI_WR, b, a, m, d);
        for (int i = 1; i < n; i++)
            ctl.issue(1'b0, sdci_pkg::SDCI_NOP, b, a, 2'h0, d + 16'(i));
        ctl.fill(1'b1, 2'h0);
    endtask
    // Read burst; rr adds a second read of column 4 one cycle later, m is the
    // mask sampled one edge after the read. Words are captured into got.
    task automatic rd(input logic [1:0] b, input logic [11:0] a, input int n, input int cl,
                      input logic rr, input logic [1:0] m);
        ctl.issue(1'b0, sdci_pkg::SDCI_RD, b, a, 2'h0, dq_in);
        ctl.fill(~rr, m);
        repeat (cl - 2) ctl.fill(1'b1, 2'h0);
        // Each word is taken at the edge after it appears, as the controller would.
        for (int i = 0; i < n; i++) begin
            ctl.fill(1'b1, 2'h0);
            got[i] = dq_out;
            oe[i]  = dq_oe_n;
        end
        ctl.fill(1'b1, 2'h0);
        chk(32'(dq_oe_n), 32'h3);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [8:0] c;
        int         cl;
        rows = '{'{12'h020, 9'h3, 4'h1}, '{12'h021, 9'h3, 4'h2}, '{12'h022, 9'h5, 4'h4},
                 '{12'h023, 9'h6, 4'h8}, '{12'h03a, 9'h6, 4'h4}, '{12'h033, 9'h1, 4'h8},
                 '{12'h02b, 9'h5, 4'h8}};
        repeat (16) @(posedge pclk);
        chk(32'(dq_oe_n), 32'h3);
        presetn <= 1'b1;
        @(posedge pclk);
        rdreg(`SDCI_OFS_STATUS, 32'h10);
        rdreg(`SDCI_OFS_MODE, 32'h020);
        rdreg(`SDCI_OFS_CTRL, `SDCI_CTRL_RST);
        $display("reset test done");
        // Fill columns 0 to 7 of bank 0 row 5 with a known pattern.
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h023);
        cmd(sdci_pkg::SDCI_ACT, 2'h0, 12'h005);
        wr(2'h0, 12'h000, 8, 2'h0, 16'ha000);
        for (int r = 0; r < 7; r++) begin
            cmd(sdci_pkg::SDCI_MRS, 2'h0, rows[r].mode);
            cl = (rows[r].mode[6:4] == 3'h3) ? 3 : 2;
            rd(2'h0, {3'h0, rows[r].col}, rows[r].len, cl, 1'b0, 2'h0);
            for (int i = 0; i < rows[r].len; i++) begin
                c = rows[r].mode[3] ? rows[r].col ^ 9'(i) : (rows[r].col & ~9'(rows[r].len - 1))
                    | ((rows[r].col + 9'(i)) & 9'(rows[r].len - 1));
                chk(32'(got[i]), 32'(16'ha000 | 16'(c)));
            end
            $display("burst row %0d done", r);
        end
        // Second read one cycle after the first cuts its burst short.
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h022);
        rd(2'h0, 12'h000, 5, 2, 1'b1, 2'h0);
        for (int i = 0; i < 5; i++)
            chk(32'(got[i]), (i == 0) ? 32'ha000 : 32'ha003 + i);
        rd(2'h0, 12'h000, 4, 2, 1'b0, 2'h2);
        chk(32'(oe[1]), 32'h2);
        chk(32'(oe[2]), 32'h0);
        $display("random read and read mask done");
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h020);
        wr(2'h0, 12'h001, 1, 2'h2, 16'h1234);
        wr(2'h0, 12'h001, 1, 2'h1, 16'h56ff);
        rd(2'h0, 12'h001, 1, 2, 1'b0, 2'h0);
        chk(32'(got[0]), 32'h5634);
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h022);
        wr(2'h0, 12'h008, 4, 2'h0, 16'hc000);
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h222);
        wr(2'h0, 12'h008, 4, 2'h0, 16'hb000);
        rd(2'h0, 12'h008, 4, 2, 1'b0, 2'h0);
        for (int i = 0; i < 4; i++)
            chk(32'(got[i]), (i == 0) ? 32'hb000 : 32'hc000 + i);
        $display("write mask and single write done");
        // Bank 2 closes itself after an auto-precharge write; bank 0 stays open.
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h020);
        cmd(sdci_pkg::SDCI_ACT, 2'h2, 12'h007);
        wr(2'h2, 12'h400, 1, 2'h0, 16'hd222);
        rdreg(`SDCI_OFS_STATUS, 32'h11);
        cmd(sdci_pkg::SDCI_ACT, 2'h2, 12'h007);
        rdreg(`SDCI_OFS_STATUS, 32'h15);
        rd(2'h2, 12'h000, 1, 2, 1'b0, 2'h0);
        chk(32'(got[0]), 32'hd222);
        rd(2'h0, 12'h000, 1, 2, 1'b0, 2'h0);
        chk(32'(got[0]), 32'ha000);
        cmd(sdci_pkg::SDCI_PRE, 2'h0, 12'h400);
        rdreg(`SDCI_OFS_STATUS, 32'h10);
        $display("bank test done");
        apb(1'b1, `SDCI_OFS_CTRL, 32'h3);
        cmd(sdci_pkg::SDCI_REF, 2'h0, 12'h000);
        rdreg(`SDCI_OFS_REFCNT, 32'h1);
        // The power state moves one edge after clock enable changes, so let it pass.
        ctl.pwr(1'b0);
        ctl.fill(1'b1, 2'h0);
        rdreg(`SDCI_OFS_STATUS, 32'h20);
        ctl.pwr(1'b1);
        ctl.fill(1'b1, 2'h0);
        rdreg(`SDCI_OFS_STATUS, 32'h10);
        // Clock enable low in mid-burst suspends the burst instead of powering down.
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h022);
        ctl.issue(1'b0, sdci_pkg::SDCI_RD, 2'h0, 12'h000, 2'h0, dq_in);
        ctl.pwr(1'b0);
        ctl.fill(1'b1, 2'h0);
        rdreg(`SDCI_OFS_STATUS, 32'h140);
        ctl.pwr(1'b1);
        repeat (3) ctl.fill(1'b1, 2'h0);
        ctl.pwr(1'b0);
        cmd(sdci_pkg::SDCI_REF, 2'h0, 12'h000);
        repeat (320) ctl.fill(1'b1, 2'h0);
        rdreg(`SDCI_OFS_STATUS, 32'h80);
        rdreg(`SDCI_OFS_REFCNT, 32'h2);
        ctl.pwr(1'b1);
        $display("refresh and power test done");
        // Disabled decoder and a write to the read-only mode register change nothing; an unmapped read is refused.
        apb(1'b1, `SDCI_OFS_CTRL, 32'h0);
        cmd(sdci_pkg::SDCI_MRS, 2'h0, 12'h023);
        apb(1'b1, `SDCI_OFS_MODE, 32'h3ff);
        rdreg(`SDCI_OFS_MODE, 32'h022);
        apb(1'b1, `SDCI_OFS_CTRL, 32'h2);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd_q, 32'h0);
        $display("register test done");
        results();
    end
endmodule // sdci_top_tb
